// ==== verilog/dpmm_top.sv ====
/*
 pin multiplexing and boot mode capture for the signal processor.
 assumes core logic on core_clk_i supplies flag, bus and serial values.
*/
// Functional notes
// [RULE1] external bus configuration fixed only in reset, held while running
// [RULE2] serial port one pins reassignable by software at any time
// [RULE3] shared pins keep interrupt and flag functions both live
// [RULE4] enabled interrupt fires when pin asserted, externally or by own flag
// [RULE5] mode pins read only in reset, then serve as flags zero to three
// [RULE6] mode chosen from pin C during reset, no change while running
// [RULE7] pin C low: full memory mode, byte DMA, 14 address, 24 data pins
// [RULE8] full memory mode drives upper 8 data pins as byte addresses
// [RULE9] host mode enables internal DMA port with limited addressing
// [RULE10] control field remaps serial port one to interrupts and flags
// [RULE11] pin C high at reset selects host mode with internal DMA pins
// [RULE12] six interrupts: one edge, two level, three configurable; code makes only bit 2 configurable, with bits 0, 1 and 5 edge-only
// [RULE13] mode pins captured at reset release edge and held until reset
`timescale 1ns/100ps
module dpmm_top (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// mode/flag pins 0..3
	input wire logic [3:0] prog_flag_in_i,
	input wire logic [3:0] prog_flag_out_val_i,
	input wire logic [3:0] prog_flag_dir_i,
	output logic [3:0] prog_flag_out_o,
	output logic [3:0] prog_flag_oe_o,
	output logic [3:0] prog_flag_rd_o,
	output logic host_mode_o,
	output logic byte_dma_port_en_o,
	output logic internal_dma_port_en_o,
	// shared interrupt/flag pins 4..7
	input wire logic [3:0] shared_pin_in_i,
	input wire logic [3:0] shared_flag_out_val_i,
	input wire logic [3:0] shared_flag_dir_i,
	output logic [3:0] shared_pin_out_o,
	output logic [3:0] shared_pin_oe_o,
	output logic [3:0] shared_flag_rd_o,
	input wire logic irq_sense_edge_i,
	input wire logic [5:0] interrupt_mask_reg_i,
	output logic [5:0] irq_pending_o,
	input wire logic [5:0] irq_clear_i,
	// serial port one
	input wire logic serial_port_one_irq_mode_i,
	input wire logic port1_rx_frame_sync_i,
	input wire logic port1_tx_frame_sync_i,
	input wire logic port1_rx_data_i,
	input wire logic port1_tx_data_val_i,
	input wire logic alt_flag_output_val_i,
	output logic port1_tx_data_o,
	output logic port1_rx_frame_sync_o,
	output logic port1_tx_frame_sync_o,
	output logic port1_rx_data_o,
	output logic alt_flag_input_o,
	// external bus
	input wire logic [13:0] core_addr_i,
	input wire logic [23:0] core_data_out_i,
	input wire logic [7:0] core_byte_addr_i,
	input wire logic core_byte_access_i,
	input wire logic core_data_oe_i,
	output logic [13:0] ext_addr_o,
	output logic [23:0] ext_data_out_o,
	output logic [23:0] ext_data_oe_o
);
	logic [3:0] mode_sync;
	logic [3:0] shared_act_sync;
	logic [2:0] sp1_act_sync;
	logic [3:0] mode_q;
	dpmm_pkg::dpmm_mode_e op_mode_q;
	// runs through reset so the mode straps are sampled while reset is low
	dpmm_sync #(.W(4)) u_mode_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(1'b1),
		.async_i(prog_flag_in_i),
		.sync_o(mode_sync)
	);
	dpmm_sync #(.W(4)) u_shared_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(~shared_pin_in_i),
		.sync_o(shared_act_sync)
	);
	// synchronised inverted so a cleared stage reads as an idle high pin, no false edge
	wire [3:0] shared_sync = ~shared_act_sync;
	dpmm_sync #(.W(3)) u_sp1_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.async_i({port1_rx_data_i, ~port1_tx_frame_sync_i, ~port1_rx_frame_sync_i}),
		.sync_o(sp1_act_sync)
	);

	// mode capture follows pins while in reset and freezes at the release edge
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			mode_q <= mode_sync; // RULE5 RULE13
			op_mode_q <= mode_sync[dpmm_pkg::MODE_C_BIT] ? dpmm_pkg::DPMM_HOST
				: dpmm_pkg::DPMM_FULL_MEM; // RULE6 RULE11 RULE1
		end
	end

	wire host_w = (op_mode_q == dpmm_pkg::DPMM_HOST);
	wire [3:0] flag_oe_w = rst_n_i ? prog_flag_dir_i : dpmm_pkg::FLAG_RST; // RULE5

	// shared pins: flag drive and interrupt sense are both active
	wire [3:0] shared_oe_w = rst_n_i ? shared_flag_dir_i : 4'h0;
	wire [3:0] shared_lvl_w;
	genvar g;
	for (g = 0; g < 4; g++) begin : g_shared
		// an output flag asserts its own interrupt (active low pin)
		assign shared_lvl_w[g] = shared_oe_w[g] ? shared_flag_out_val_i[g]
			: shared_sync[g]; // RULE3 RULE4
	end

	// serial port one remap
	wire [2:0] sp1_w = {sp1_act_sync[2], ~sp1_act_sync[1:0]};
	wire sp1_alt_w = serial_port_one_irq_mode_i; // RULE2 RULE10
	wire irq_a_w = sp1_alt_w & ~sp1_w[0];
	wire irq_b_w = sp1_alt_w & ~sp1_w[1];

	// interrupt request levels, low active pins: bit order
	// 0 serial_alt_irq_a 1 serial_alt_irq_b 2 irq_configurable_sense
	// 3 irq_level_b 4 irq_level_a 5 irq_edge_only
	wire [5:0] req_w = {~shared_lvl_w[3], ~shared_lvl_w[2], ~shared_lvl_w[1],
		~shared_lvl_w[0], irq_b_w, irq_a_w};
	logic [5:0] req_q;
	logic [5:0] pend_q;
	wire [5:0] edge_sel_w = {1'b1, 1'b0, 1'b0, irq_sense_edge_i, 1'b1, 1'b1}; // RULE12
	wire [5:0] hit_w = edge_sel_w & req_w & ~req_q | ~edge_sel_w & req_w;
	wire [5:0] pend_d = (pend_q & ~irq_clear_i & edge_sel_w)
		| (hit_w & interrupt_mask_reg_i); // RULE4

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			req_q <= '0;
			pend_q <= '0;
		end else begin
			req_q <= req_w;
			pend_q <= pend_d;
		end
	end

	// external bus: full memory mode byte accesses put the byte address on the data msbs
	wire byte_drv_w = !host_w && core_byte_access_i; // RULE8
	wire [23:0] data_w = byte_drv_w ? {core_byte_addr_i, core_data_out_i[15:0]}
		: core_data_out_i;
	wire [23:0] doe_w = (!host_w && core_data_oe_i) ? 24'hffffff
		: byte_drv_w ? 24'hff0000 : host_w ? {{16{core_data_oe_i}}, 8'h00} : 24'h000000; // RULE7 RULE9
	wire [13:0] addr_w = host_w ? {13'h0000, core_addr_i[0]} : core_addr_i; // RULE9

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			prog_flag_out_o <= '0;
			prog_flag_oe_o <= '0;
			prog_flag_rd_o <= '0;
			shared_pin_out_o <= '0;
			shared_pin_oe_o <= '0;
			shared_flag_rd_o <= '0;
			irq_pending_o <= '0;
			host_mode_o <= 1'b0;
			byte_dma_port_en_o <= 1'b0;
			internal_dma_port_en_o <= 1'b0;
			port1_tx_data_o <= 1'b0;
			port1_rx_frame_sync_o <= 1'b0;
			port1_tx_frame_sync_o <= 1'b0;
			port1_rx_data_o <= 1'b0;
			alt_flag_input_o <= 1'b0;
			ext_addr_o <= '0;
			ext_data_out_o <= '0;
			ext_data_oe_o <= '0;
		end else begin
			prog_flag_out_o <= prog_flag_out_val_i;
			prog_flag_oe_o <= flag_oe_w;
			prog_flag_rd_o <= flag_oe_w & prog_flag_out_val_i | ~flag_oe_w & mode_sync; // RULE5
			shared_pin_out_o <= shared_flag_out_val_i;
			shared_pin_oe_o <= shared_oe_w;
			shared_flag_rd_o <= shared_lvl_w; // RULE3
			irq_pending_o <= pend_d;
			host_mode_o <= host_w;
			byte_dma_port_en_o <= !host_w; // RULE7
			internal_dma_port_en_o <= host_w; // RULE11
			port1_tx_data_o <= sp1_alt_w ? alt_flag_output_val_i : port1_tx_data_val_i; // RULE10
			port1_rx_frame_sync_o <= sp1_alt_w ? 1'b0 : sp1_w[0];
			port1_tx_frame_sync_o <= sp1_alt_w ? 1'b0 : sp1_w[1];
			port1_rx_data_o <= sp1_alt_w ? 1'b0 : sp1_w[2];
			alt_flag_input_o <= sp1_alt_w ? sp1_w[2] : 1'b0;
			ext_addr_o <= addr_w;
			ext_data_out_o <= data_w;
			ext_data_oe_o <= doe_w;
		end
	end

	a_mode_held: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE1
		rst_n_i && $past(rst_n_i) |-> $stable(op_mode_q))
		else $error("mode changed while running");
	// the straps need the synchroniser filled, so only a full reset window is judged
	a_mode_from_c: assert property (@(posedge core_clk_i) // RULE6
		!rst_n_i [*4] |=> (op_mode_q == dpmm_pkg::DPMM_HOST)
		== $past(mode_sync[dpmm_pkg::MODE_C_BIT]))
		else $error("mode not taken from pin c");
	a_capture_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE13
		$past(rst_n_i) |-> $stable(mode_q))
		else $error("captured mode pins moved");
	a_flag_no_drive: assert property (@(posedge core_clk_i) // RULE5
		!rst_n_i |=> prog_flag_oe_o == 4'h0)
		else $error("flag driven in reset");
	a_host_enables: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE7
		$past(rst_n_i) |-> internal_dma_port_en_o == host_mode_o
		&& byte_dma_port_en_o == !host_mode_o)
		else $error("port enables disagree with mode");
	a_host_addr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE9
		$past(rst_n_i) && host_mode_o |-> ext_addr_o[13:1] == 13'h0000)
		else $error("host mode drove full address");
	a_byte_addr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE8
		$past(rst_n_i) && $past(byte_drv_w) |->
		ext_data_out_o[23:16] == $past(core_byte_addr_i) && &ext_data_oe_o[23:16])
		else $error("byte address not on data msbs");
	a_sp1_remap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE10
		$past(rst_n_i) && $past(sp1_alt_w) |->
		port1_tx_data_o == $past(alt_flag_output_val_i))
		else $error("flag output not on tx data");
	a_own_flag_irq: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE4
		shared_oe_w[0] && !shared_flag_out_val_i[0] && interrupt_mask_reg_i[2]
		&& !irq_sense_edge_i |=> irq_pending_o[2])
		else $error("own flag did not raise interrupt");
	a_level_live: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE3
		!shared_lvl_w[1] && interrupt_mask_reg_i[3] |=> irq_pending_o[3])
		else $error("level interrupt lost on shared pin");
endmodule // dpmm_top

// ==== inc/dpmm_pkg.sv ====
/*
 pin mode mux package: mode pin positions, mode encodings, pin widths, reset values.
 assumes a single processor clock domain.
*/
package dpmm_pkg;
	localparam int MODE_PINS = 4;
	localparam int MODE_C_BIT = 2;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 24;
	localparam int BYTE_ADDR_W = 8;
	localparam int HOST_W = 16;
	localparam int SYNC_STAGES = 2;
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [3:0] FLAG_RST = 4'h0;
	typedef enum logic [1:0] {
		DPMM_FULL_MEM = 2'b01,
		DPMM_HOST = 2'b10
	} dpmm_mode_e;
endpackage

// ==== verilog/dpmm_sync.sv ====
/*
 two flip-flop synchroniser for a vector of pin inputs.
 assumes inputs are asynchronous to core_clk_i.
*/
`timescale 1ns/100ps
module dpmm_sync #(
	parameter int W = 1
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end
	assign sync_o = sync_q;
endmodule // dpmm_sync

// ==== verification/dpmm_pin_model.sv ====
/*
 far-side pin model: resolves the mode/flag pins and the shared interrupt/flag pins.
 assumes pins idle high through pull-ups when nobody drives them.
*/
`timescale 1ns/100ps
module dpmm_pin_model (
	input wire logic [3:0] flag_out_i,
	input wire logic [3:0] flag_oe_i,
	input wire logic [3:0] flag_ext_i,
	input wire logic [3:0] flag_ext_en_i,
	input wire logic [3:0] shared_out_i,
	input wire logic [3:0] shared_oe_i,
	input wire logic [3:0] shared_ext_i,
	input wire logic [3:0] shared_ext_en_i,
	output logic [3:0] flag_pin_o,
	output logic [3:0] shared_pin_o
);
	// device drive wins, then the external driver, else the pull-up
	assign flag_pin_o = (flag_oe_i & flag_out_i)
		| (~flag_oe_i & ((flag_ext_en_i & flag_ext_i) | ~flag_ext_en_i));
	// own flag output loops back into the interrupt input
	assign shared_pin_o = (shared_oe_i & shared_out_i)
		| (~shared_oe_i & ((shared_ext_en_i & shared_ext_i) | ~shared_ext_en_i));
endmodule // dpmm_pin_model

// ==== verification/tb_top.sv ====
/*
 testbench for the pin mode mux: boot straps, flags, shared irqs, serial remap, bus.
 assumes the far-side pin model and the design top module.
*/
`timescale 1ns/100ps
module tb_top;
	logic core_clk_i = 0;
	logic rst_n_i = 0;
	logic [3:0] fo, foe, frd, fx, fxe, so, soe, srd, sx, sxe, fpin, spin, fval, fdir, sval, sdir;
	logic hm, bde, ide, sm, rfs, tfs, rdi, tdv, afo, tdo, rfo, tfo, rdo, afi, bacc, doe, edg;
	logic [5:0] msk, pend, clr;
	logic [13:0] cad, ead;
	logic [23:0] cdo, edo, eoe;
	logic [7:0] bad;
	int failures = 0;
	int compares = 0;
	initial forever #2 core_clk_i = ~core_clk_i;
	dpmm_pin_model pm (.flag_out_i(fo), .flag_oe_i(foe), .flag_ext_i(fx), .flag_ext_en_i(fxe),
		.shared_out_i(so), .shared_oe_i(soe), .shared_ext_i(sx), .shared_ext_en_i(sxe),
		.flag_pin_o(fpin), .shared_pin_o(spin));
	dpmm_top dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .prog_flag_in_i(fpin),
		.prog_flag_out_val_i(fval), .prog_flag_dir_i(fdir), .prog_flag_out_o(fo),
		.prog_flag_oe_o(foe), .prog_flag_rd_o(frd), .host_mode_o(hm),
		.byte_dma_port_en_o(bde), .internal_dma_port_en_o(ide), .shared_pin_in_i(spin),
		.shared_flag_out_val_i(sval), .shared_flag_dir_i(sdir), .shared_pin_out_o(so),
		.shared_pin_oe_o(soe), .shared_flag_rd_o(srd), .irq_sense_edge_i(edg),
		.interrupt_mask_reg_i(msk), .irq_pending_o(pend), .irq_clear_i(clr),
		.serial_port_one_irq_mode_i(sm), .port1_rx_frame_sync_i(rfs),
		.port1_tx_frame_sync_i(tfs), .port1_rx_data_i(rdi), .port1_tx_data_val_i(tdv),
		.alt_flag_output_val_i(afo), .port1_tx_data_o(tdo), .port1_rx_frame_sync_o(rfo),
		.port1_tx_frame_sync_o(tfo), .port1_rx_data_o(rdo), .alt_flag_input_o(afi),
		.core_addr_i(cad), .core_data_out_i(cdo), .core_byte_addr_i(bad),
		.core_byte_access_i(bacc), .core_data_oe_i(doe), .ext_addr_o(ead),
		.ext_data_out_o(edo), .ext_data_oe_o(eoe));
	task step(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task do_reset(input logic [3:0] straps);
		rst_n_i = 0;
		fx = straps;
		fxe = 4'hf;
		step(4);
		chk(foe, 4'h0);
		rst_n_i = 1;
		step(2);
	endtask
	task print_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#2000;
		failures++;
		print_verdict;
	end
	initial begin
		{fval, fdir, sval, sdir, sx, sxe, sm, rdi, tdv, afo, bacc, doe, edg, msk, clr} = '0;
		{cad, cdo, bad} = '0;
		rfs = 1;
		tfs = 1;
		do_reset(4'hb);
		chk({hm, bde, ide}, 3'b010);
		fx = 4'h4;
		step(5);
		chk({hm, bde, ide}, 3'b010);
		chk(frd, 4'h4);
		fxe = 4'hc;
		fdir = 4'h3;
		fval = 4'h2;
		step(1);
		chk({foe, fo[1:0]}, 6'h0e);
		step(3);
		chk(frd, 4'h6);
		cad = 14'h2abc;
		cdo = 24'h123456;
		bad = 8'ha5;
		bacc = 1;
		doe = 1;
		step(1);
		chk(ead, 14'h2abc);
		chk(edo, 24'ha53456);
		chk(eoe[23:16], 8'hff);
		bacc = 0;
		step(1);
		chk(edo, 24'h123456);
		msk = 6'h3f;
		sxe = 4'h2;
		step(5);
		chk({pend[4:2], srd[1]}, 4'h4);
		sxe = 4'h0;
		step(5);
		chk(pend[4:2], 3'h0);
		sdir = 4'h8;
		sval = 4'h7;
		step(5);
		chk({pend[5], soe}, 5'h18);
		sdir = 4'h0;
		step(5);
		chk(pend[5], 1'b1);
		clr = 6'h20;
		step(1);
		clr = 6'h0;
		step(1);
		chk(pend[5], 1'b0);
		sdir = 4'h1;
		sval = 4'he;
		step(2);
		chk({pend[2], srd[0]}, 2'b10);
		sdir = 4'h0;
		msk = 6'h0;
		sxe = 4'h4;
		step(5);
		chk(pend, 6'h0);
		sxe = 4'h0;
		rdi = 1;
		tdv = 1;
		step(4);
		chk({tdo, rdo}, 2'b11);
		sm = 1;
		msk = 6'h3f;
		rfs = 0;
		step(5);
		chk({tdo, afi, rdo, pend[0]}, 4'h5);
		rfs = 1;
		tfs = 0;
		step(5);
		chk(pend[1], 1'b1);
		edg = 1;
		sxe = 4'h1;
		step(5);
		sxe = 4'h0;
		step(5);
		chk(pend[2], 1'b1);
		clr = 6'h04;
		step(1);
		clr = 6'h0;
		step(1);
		chk(pend[2], 1'b0);
		do_reset(4'h4);
		chk({hm, bde, ide}, 3'b101);
		cad = 14'h3fff;
		step(1);
		chk(ead[13:1], 13'h0);
		chk(ead[0], 1'b1);
		chk(eoe, 24'hffff00);
		print_verdict;
	end
endmodule // tb_top
